// ==== shared/secure_fe_pkg.sv ====
`default_nettype none
package secure_fe_pkg;
    // Carrier periods per emitted bit in character mode
    localparam int         ETU_CARRIER_CYCLES = 372;
    localparam logic [8:0] ETU_LAST           = 9'(ETU_CARRIER_CYCLES - 1);
    // Character frame: start, 8 data, parity, 2 guard ETUs
    localparam logic [3:0] FRAME_ETUS         = 4'hc;
    // Answer-to-reset length in bytes
    localparam logic [3:0] ATR_BYTES          = 4'h8;
    // Memory shape
    localparam int         ZONES              = 8;
    localparam int         ZONE_BYTES         = 128;
    localparam int         PAGE_BYTES         = 16;
    // Self-timed programming time
    localparam int         T_WR_US            = 5000;
    localparam int         CLK_MHZ            = 25;
    localparam int         WR_CYCLES          = T_WR_US * CLK_MHZ;
    // Device byte layout: {device address, zone, read}
    localparam int         DEV_ADDR_LSB       = 4;
    localparam int         ZONE_LSB           = 1;
    localparam int         RW_BIT             = 0;
    // Depth of the character transmit buffer
    localparam int         TX_FIFO_DEPTH      = 4;

    typedef enum logic [2:0] {
        TW_IDLE = 3'h0,
        TW_DEV  = 3'h1,
        TW_ADR  = 3'h2,
        TW_WDAT = 3'h3,
        TW_RDAT = 3'h4,
        TW_ACK  = 3'h5,
        TW_MACK = 3'h6
    } tw_state_t;
endpackage
`default_nettype wire

// ==== core/byte_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // Drain side
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    wr_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // Handshake flags
    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = store[rd_ptr];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointer and level update
    always_comb
    begin
        next_rd_ptr = rd_ptr;
        next_wr_ptr = wr_ptr;
        next_count  = count;
        if (push)
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
        if (pop)
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
        if (push && !pop)
            next_count = count + (AW+1)'(1);
        else if (pop && !push)
            next_count = count - (AW+1)'(1);
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            rd_ptr <= next_rd_ptr;
            wr_ptr <= next_wr_ptr;
            count  <= next_count;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk_i)
    begin
        if (push)
            store[wr_ptr] <= in_data_i;
    end
endmodule
`default_nettype wire

// ==== core/secure_front_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module secure_front_end
    import secure_fe_pkg::*;
#(
    parameter int WRITE_CYCLES = WR_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    // Pins
    input  wire logic        SCL_CLK_I,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_O,
    input  wire logic        CARD_RST_N_I,
    // Configuration from the secure core
    input  wire logic [3:0]  DEV_ADDR_I,
    input  wire logic [63:0] ATR_I,
    input  wire logic [7:0]  ZONE_RD_OK_I,
    input  wire logic [7:0]  ZONE_WR_OK_I,
    input  wire logic        AUTH_OK_I,
    input  wire logic [1:0]  KEY_SEL_I,
    input  wire logic [31:0] KEYS_I,
    // Status
    output logic             MODE_ASYNC_O,
    output logic             BUSY_O
);
    localparam int BW = $clog2(WRITE_CYCLES + 1);

    // Keystream step, used on every written and read byte
    function automatic logic [7:0] ks_step(input logic [7:0] s);
        ks_step = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    logic [2:0]  scl_q;
    logic [2:0]  sda_q;
    logic [2:0]  rst_q;
    logic        scl_s;
    logic        sda_s;
    logic        rst_s;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        rst_rise;

    // Pin synchronisers; reset input idles high like its pull-up
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            rst_q <= 3'h7;
        end
        else
        begin
            scl_q <= {scl_q[1:0], SCL_CLK_I};
            sda_q <= {sda_q[1:0], SDA_I};
            rst_q <= {rst_q[1:0], CARD_RST_N_I};
        end
    end

    // Edges and bus conditions seen after synchronisation
    assign scl_s      = scl_q[1];
    assign sda_s      = sda_q[1];
    assign rst_s      = rst_q[1];
    assign scl_rise   = scl_s & ~scl_q[2];
    assign scl_fall   = ~scl_s & scl_q[2];
    assign start_cond = scl_s & scl_q[2] & sda_q[2] & ~sda_s;
    assign stop_cond  = scl_s & scl_q[2] & ~sda_q[2] & sda_s;
    assign rst_rise   = rst_s & ~rst_q[2];

    tw_state_t   state;
    tw_state_t   next_state;
    tw_state_t   ack_to;
    tw_state_t   next_ack_to;
    logic [7:0]  sh;
    logic [7:0]  next_sh;
    logic [3:0]  bits;
    logic [3:0]  next_bits;
    logic [2:0]  zone;
    logic [2:0]  next_zone;
    logic [6:0]  ptr;
    logic [6:0]  next_ptr;
    logic        tw_oe;
    logic        next_tw_oe;
    logic        dirty;
    logic        next_dirty;
    logic [BW-1:0] busy_cnt;
    logic [BW-1:0] next_busy_cnt;
    logic        mode_async;
    logic        next_mode_async;
    logic [7:0]  ks;
    logic [7:0]  next_ks;
    logic [7:0]  ks_mask;
    logic [7:0]  rd_byte;
    logic        mem_we;
    logic [9:0]  mem_wa;
    logic [7:0]  mem_wd;
    logic [3:0]  tx_bits;
    logic [3:0]  next_tx_bits;
    logic        tx_own;
    logic [7:0]  mem [0:ZONES*ZONE_BYTES-1];

    // Own character bits move the line while the free-running carrier is high,
    // which would otherwise look like a start and drop character mode mid-frame
    assign tx_own = mode_async & (tx_bits != 4'h0);

    // Zoned user memory
    assign ks_mask = AUTH_OK_I ? ks : 8'h00;
    assign rd_byte = mem[{zone, ptr}] ^ ks_mask;

    // Mode selection and two-wire protocol
    always_comb
    begin
        next_state      = state;
        next_ack_to     = ack_to;
        next_sh         = sh;
        next_bits       = bits;
        next_zone       = zone;
        next_ptr        = ptr;
        next_tw_oe      = tw_oe;
        next_dirty      = dirty;
        next_mode_async = mode_async;
        next_busy_cnt   = (busy_cnt != '0) ? busy_cnt - BW'(1) : busy_cnt;
        next_ks         = AUTH_OK_I ? ks : KEYS_I[{KEY_SEL_I, 3'h0} +: 8];
        mem_we          = 1'b0;
        mem_wa          = {zone, ptr};
        mem_wd          = sh ^ ks_mask;
        if (!rst_s)
        begin
            next_mode_async = 1'b1;
            next_state      = TW_IDLE;
            next_tw_oe      = 1'b0;
        end
        else if (start_cond && !tx_own)
        begin
            next_mode_async = 1'b0;
            next_state      = TW_DEV;
            next_bits       = 4'h0;
            next_tw_oe      = 1'b0;
        end
        else if (stop_cond)
        begin
            next_state = TW_IDLE;
            next_tw_oe = 1'b0;
            if (dirty)
            begin
                next_busy_cnt = BW'(WRITE_CYCLES);
                next_dirty    = 1'b0;
            end
        end
        else if (!mode_async)
        begin
            unique case (state)
                TW_IDLE: ;
                TW_DEV, TW_ADR, TW_WDAT:
                begin
                    if (scl_rise && bits != 4'h8)
                    begin
                        next_sh   = {sh[6:0], sda_s};
                        next_bits = bits + 4'h1;
                    end
                    else if (scl_fall && bits == 4'h8)
                    begin
                        next_bits  = 4'h0;
                        next_state = TW_ACK;
                        next_tw_oe = 1'b1;
                        next_ack_to = TW_WDAT;
                        if (state == TW_DEV)
                        begin
                            next_zone   = sh[ZONE_LSB +: 3];
                            next_ack_to = sh[RW_BIT] ? TW_RDAT : TW_ADR;
                            if (sh[DEV_ADDR_LSB +: 4] != DEV_ADDR_I || busy_cnt != '0 ||
                                (sh[RW_BIT] && !ZONE_RD_OK_I[sh[ZONE_LSB +: 3]]))
                            begin
                                next_state = TW_IDLE;
                                next_tw_oe = 1'b0;
                            end
                        end
                        else if (state == TW_ADR)
                            next_ptr = sh[6:0];
                        else if (ZONE_WR_OK_I[zone])
                        begin
                            mem_we     = 1'b1;
                            next_ptr   = {ptr[6:4], ptr[3:0] + 4'h1};
                            next_dirty = 1'b1;
                            next_ks    = ks_step(ks);
                        end
                        else
                        begin
                            next_state = TW_IDLE;
                            next_tw_oe = 1'b0;
                        end
                    end
                end
                TW_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_state = ack_to;
                        next_tw_oe = 1'b0;
                        if (ack_to == TW_RDAT)
                        begin
                            next_sh    = rd_byte;
                            next_tw_oe = ~rd_byte[7];
                            next_ks    = ks_step(ks);
                        end
                    end
                end
                TW_RDAT:
                begin
                    if (scl_rise)
                        next_bits = bits + 4'h1;
                    else if (scl_fall && bits == 4'h8)
                    begin
                        next_tw_oe = 1'b0;
                        next_state = TW_MACK;
                        next_bits  = 4'h0;
                    end
                    else if (scl_fall)
                    begin
                        next_sh    = {sh[6:0], 1'b0};
                        next_tw_oe = ~sh[6];
                    end
                end
                TW_MACK:
                begin
                    if (scl_rise && sda_s)
                        next_state = TW_IDLE;
                    else if (scl_rise)
                    begin
                        next_ptr  = ptr + 7'h01;
                        next_bits = 4'h1;
                    end
                    else if (scl_fall && bits == 4'h1)
                    begin
                        next_sh    = rd_byte;
                        next_tw_oe = ~rd_byte[7];
                        next_state = TW_RDAT;
                        next_bits  = 4'h0;
                        next_ks    = ks_step(ks);
                    end
                end
                default: next_state = TW_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state      <= TW_IDLE;
            ack_to     <= TW_IDLE;
            sh         <= 8'h00;
            bits       <= 4'h0;
            zone       <= 3'h0;
            ptr        <= 7'h00;
            tw_oe      <= 1'b0;
            dirty      <= 1'b0;
            busy_cnt   <= '0;
            mode_async <= 1'b0;
            ks         <= 8'h00;
        end
        else
        begin
            state      <= next_state;
            ack_to     <= next_ack_to;
            sh         <= next_sh;
            bits       <= next_bits;
            zone       <= next_zone;
            ptr        <= next_ptr;
            tw_oe      <= next_tw_oe;
            dirty      <= next_dirty;
            busy_cnt   <= next_busy_cnt;
            mode_async <= next_mode_async;
            ks         <= next_ks;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
    end

    logic [3:0]  atr_idx;
    logic [3:0]  next_atr_idx;
    logic [9:0]  tx_sh;
    logic [9:0]  next_tx_sh;
    logic [8:0]  etu_cnt;
    logic [8:0]  next_etu_cnt;
    logic        tx_oe;
    logic        next_tx_oe;
    logic        push_ready;
    logic [7:0]  pop_data;
    logic        pop_valid;
    logic        pop_ready;

    // Answer-to-reset bytes queue up for the character transmitter
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i       (CLK_I),
        .rst_i       (SYS_RST_I),
        .in_data_i   (ATR_I[{~atr_idx[2:0], 3'h0} +: 8]),
        .in_valid_i  (atr_idx != ATR_BYTES),
        .in_ready_o  (push_ready),
        .out_data_o  (pop_data),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready)
    );

    assign pop_ready = mode_async & rst_s & (tx_bits == 4'h0);

    // Loader and character transmitter
    always_comb
    begin
        next_atr_idx = atr_idx;
        next_tx_sh   = tx_sh;
        next_tx_bits = tx_bits;
        next_etu_cnt = etu_cnt;
        next_tx_oe   = tx_oe;
        if (atr_idx != ATR_BYTES && push_ready)
            next_atr_idx = atr_idx + 4'h1;
        if (rst_rise && mode_async)
            next_atr_idx = 4'h0;
        if (!mode_async || !rst_s)
        begin
            next_atr_idx = ATR_BYTES;
            next_tx_bits = 4'h0;
            next_tx_oe   = 1'b0;
        end
        else if (pop_valid && pop_ready)
        begin
            next_tx_sh   = {1'b1, ^pop_data, pop_data};
            next_tx_bits = FRAME_ETUS;
            next_etu_cnt = 9'h000;
            next_tx_oe   = 1'b1;
        end
        else if (tx_bits != 4'h0 && scl_rise)
        begin
            next_etu_cnt = etu_cnt + 9'h001;
            if (etu_cnt == ETU_LAST)
            begin
                next_etu_cnt = 9'h000;
                next_tx_bits = tx_bits - 4'h1;
                next_tx_oe   = (tx_bits == 4'h1) ? 1'b0 : ~tx_sh[0];
                next_tx_sh   = {1'b1, tx_sh[9:1]};
            end
        end
    end

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            atr_idx <= ATR_BYTES;
            tx_sh   <= 10'h3ff;
            tx_bits <= 4'h0;
            etu_cnt <= 9'h000;
            tx_oe   <= 1'b0;
        end
        else
        begin
            atr_idx <= next_atr_idx;
            tx_sh   <= next_tx_sh;
            tx_bits <= next_tx_bits;
            etu_cnt <= next_etu_cnt;
            tx_oe   <= next_tx_oe;
        end
    end

    // Registered pin drive and status
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            SDA_O        <= 1'b0;
            SDA_OE_O     <= 1'b0;
            MODE_ASYNC_O <= 1'b0;
            BUSY_O       <= 1'b0;
        end
        else
        begin
            SDA_O        <= 1'b0;
            SDA_OE_O     <= mode_async ? tx_oe : tw_oe;
            MODE_ASYNC_O <= mode_async;
            BUSY_O       <= (busy_cnt != '0);
        end
    end

    chk_sda_low_only: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        SDA_O == 1'b0) else $error("data line driven high");
    chk_etu_bound: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        scl_rise && tx_bits > 4'h1 && etu_cnt == ETU_LAST && mode_async && rst_s
        |=> etu_cnt == 9'h000 && tx_bits == $past(tx_bits) - 4'h1)
        else $error("bit time not 372 carrier periods");
    chk_etu_range: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        etu_cnt <= ETU_LAST) else $error("bit counter overran");
    chk_no_atr_sync: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !mode_async |=> atr_idx == ATR_BYTES && !tx_oe) else $error("answer-to-reset in two-wire mode");
    chk_atr_start: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        rst_rise && mode_async |=> atr_idx == 4'h0) else $error("answer-to-reset not started");
    chk_mode_pick: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        start_cond && rst_s && !tx_own |=> !mode_async && state == TW_DEV)
        else $error("start did not select two-wire");
    chk_mode_rst: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        !rst_s |=> mode_async && state == TW_IDLE) else $error("reset did not select character mode");
    chk_sample_rise: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        scl_rise && !mode_async && rst_s && !start_cond && !stop_cond && bits != 4'h8 &&
        (state == TW_DEV || state == TW_ADR || state == TW_WDAT)
        |=> sh[0] == $past(sda_s) && bits == $past(bits) + 4'h1) else $error("bit not sampled");
    chk_launch_fall: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state == TW_RDAT && scl_rise && rst_s && !start_cond && !stop_cond
        |=> $stable(tw_oe)) else $error("read data changed on rising clock");
    chk_addr_match: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        state == TW_DEV && scl_fall && bits == 4'h8 && rst_s && !mode_async &&
        sh[DEV_ADDR_LSB +: 4] != DEV_ADDR_I |=> state == TW_IDLE && !tw_oe)
        else $error("foreign address answered");
    chk_busy_load: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        stop_cond && dirty && rst_s |=> busy_cnt == BW'(WRITE_CYCLES) ##1 BUSY_O)
        else $error("programming cycle not started");
    chk_page_wrap: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
        mem_we |=> ptr[6:4] == $past(ptr[6:4])) else $error("page write crossed page");
endmodule
`default_nettype wire

// ==== dv/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock and wire
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Host pins
    output logic      scl_o,
    output logic      sda_low_o
);
    // Bus idles with both lines high
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // Data falls while the clock is high
    task automatic start();
        sda_low_o = 1'b0;
        wait_clk(10);
        scl_o = 1'b1;
        wait_clk(10);
        sda_low_o = 1'b1;
        wait_clk(10);
        scl_o = 1'b0;
    endtask
    // Data rises while the clock is high
    task automatic stop();
        wait_clk(2);
        sda_low_o = 1'b1;
        wait_clk(10);
        scl_o = 1'b1;
        wait_clk(10);
        sda_low_o = 1'b0;
        wait_clk(10);
    endtask
    // One bit: data set in the low phase, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic r);
        wait_clk(2);
        sda_low_o = ~b;
        wait_clk(8);
        scl_o = 1'b1;
        wait_clk(5);
        r = sda_i;
        wait_clk(5);
        scl_o = 1'b0;
    endtask
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask
    // Last byte is answered with a release
    task automatic byte_rx(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// ==== dv/secure_front_end_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module secure_front_end_bench;
    typedef struct { logic [7:0] dev; logic dev_ack; logic dat_ack; } row_t;
    logic clk = 1'b0, sys_rst = 1'b1, carrier = 1'b0, use_carrier = 1'b0, card_rst_n = 1'b1;
    logic auth_ok = 1'b0;
    logic [1:0] key_sel = 2'h0;
    logic [7:0] zone_rd_ok = 8'hff, zone_wr_ok = 8'h0f;
    logic [31:0] keys = 32'h0;
    logic scl_host, sda_low, sda_o, sda_oe, mode_async, busy, ack;
    logic [63:0] atr = 64'h3b_a1_5c_07_e2_90_4d_c6;
    logic [7:0] rd;
    int err_count = 0, check_count = 0;
    row_t rows [4] = '{'{8'h50, 1, 1}, '{8'h5c, 1, 0}, '{8'ha0, 0, 0}, '{8'h00, 0, 0}};
    // Open-drain wire with pull-up
    wire sda = ~sda_oe & ~sda_low;
    wire scl_pin = use_carrier ? carrier : scl_host;
    initial
    begin
        forever #20 clk = ~clk;
    end
    // Carrier runs only around the character frames
    always #160 if (use_carrier) carrier = ~carrier;
    host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl_host), .sda_low_o(sda_low));
    secure_front_end #(.WRITE_CYCLES(50)) dut (
        .CLK_I(clk), .SYS_RST_I(sys_rst), .SCL_CLK_I(scl_pin), .SDA_I(sda), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .CARD_RST_N_I(card_rst_n), .DEV_ADDR_I(4'h5), .ATR_I(atr),
        .ZONE_RD_OK_I(zone_rd_ok), .ZONE_WR_OK_I(zone_wr_ok), .AUTH_OK_I(auth_ok),
        .KEY_SEL_I(key_sel), .KEYS_I(keys), .MODE_ASYNC_O(mode_async), .BUSY_O(busy));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Programming cycle starts after stop and ends by itself
    task automatic wait_prog();
        host.wait_clk(4);
        check(busy, 1'b1);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) host.wait_clk(1);
        check(busy, 1'b0);
    endtask
    task automatic read_at(input logic [7:0] off, output logic [7:0] d);
        host.start();
        host.byte_tx(8'h50, ack);
        host.byte_tx(off, ack);
        host.start();
        host.byte_tx(8'h51, ack);
        check(ack, 1'b1);
        host.byte_rx(d, 1'b1);
        host.stop();
    endtask
    initial
    begin
        repeat (80000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        host.wait_clk(50);
        check(mode_async, 1'b0);
        check(sda_oe, 1'b0);
        // Address match and zone write rights, single-byte writes
        foreach (rows[i])
        begin
            host.start();
            host.byte_tx(rows[i].dev, ack);
            check(ack, rows[i].dev_ack);
            if (rows[i].dev_ack)
            begin
                host.byte_tx(8'h03, ack);
                host.byte_tx(8'ha5, ack);
                check(ack, rows[i].dat_ack);
            end
            host.stop();
            if (rows[i].dat_ack) wait_prog();
            $display("row %0d done", i);
        end
        // Page write wraps from offset 0f to 00
        host.start();
        host.byte_tx(8'h50, ack);
        host.byte_tx(8'h0f, ack);
        host.byte_tx(8'h11, ack);
        host.byte_tx(8'h22, ack);
        host.stop();
        wait_prog();
        read_at(8'h00, rd);
        check(rd, 8'h22);
        read_at(8'h03, rd);
        check(rd, 8'ha5);
        // Zone without read right refuses a read
        zone_rd_ok = 8'hfe;
        host.start();
        host.byte_tx(8'h51, ack);
        check(ack, 1'b0);
        host.stop();
        zone_rd_ok = 8'hff;
        // Authenticated write is masked by the selected key set seed
        key_sel = 2'h1;
        keys = 32'h0000_5a00;
        host.wait_clk(2);
        auth_ok = 1'b1;
        host.start();
        host.byte_tx(8'h50, ack);
        host.byte_tx(8'h20, ack);
        host.byte_tx(8'h3c, ack);
        check(ack, 1'b1);
        host.stop();
        wait_prog();
        auth_ok = 1'b0;
        read_at(8'h20, rd);
        check(rd, 8'h3c ^ 8'h5a);
        $display("two-wire test done");
        // Card reset selects character mode and starts the answer
        use_carrier = 1'b1;
        card_rst_n = 1'b0;
        host.wait_clk(20);
        check(mode_async, 1'b1);
        check(sda_oe, 1'b0);
        card_rst_n = 1'b1;
        for (int i = 0; i < 200 && sda_oe !== 1'b1; i++) host.wait_clk(1);
        repeat (186) @(posedge carrier);
        check(sda_oe, 1'b1);
        for (int b = 0; b < 8; b++)
        begin
            repeat (372) @(posedge carrier);
            check(sda_oe, !atr[56 + b]);
        end
        // Even parity, then the first guard time released
        repeat (372) @(posedge carrier);
        check(sda_oe, !(^atr[63:56]));
        repeat (372) @(posedge carrier);
        check(sda_oe, 1'b0);
        check(sda_o, 1'b0);
        $display("character test done");
        complete_run();
    end
endmodule
`default_nettype wire
